/* hw/dec_defines.svh */
`ifndef DEC_DEFINES_SVH
`define DEC_DEFINES_SVH

// instruction cycle timing
`define OSC_PER_ICYCLE 4
`define PHASE_W 2

// word layout
`define WORD_W 16
`define NIB_SECOND 4'hF
`define NIB_MOVFF 4'hC
`define HI_CALL 7'h76
`define HI_LFSR 8'hEE
`define HI_GOTO 8'hEF
`define HI_EXT_LO 8'hE8
`define HI_EXT_HI 8'hEB
`define HI_MOVLB 8'h01
`define HI_RETLW 8'h0C
`define HI_LITS 5'h01
`define HI_BRANCH 5'h1C
`define HI_BRA 5'h1A
`define HI_RCALL 5'h1B
`define HI_CPFS 5'h0C
`define HI_DECFSZ 6'h0B
`define HI_INCFSZ 6'h0F
`define HI_INFSNZ 6'h12
`define HI_DCFSNZ 6'h13
`define HI_BTFS 3'h5
`define OP_NOP 16'h0000
`define OP_CALLW 16'h0014
`define OP_RETFIE 15'h0008
`define OP_RETURN 15'h0009
`define TOP_MISC 12'h000

`endif

/* hw/dec_pkg.sv */
package dec_pkg;

    typedef enum logic [1:0] {GRP_BYTE, GRP_BIT, GRP_LIT, GRP_CTRL} group_t;
    typedef enum logic [1:0] {TBL_HOLD, TBL_POST_INC, TBL_POST_DEC, TBL_PRE_INC} tbl_mode_t;
    typedef enum logic [2:0] {ST_IDLE, ST_EXEC, ST_SECOND, ST_DBL, ST_FLUSH} state_t;

    typedef struct packed {
        group_t grp;
        logic nop;
        logic dbl;
        logic ext;
        logic [11:0] file_addr;
        logic [11:0] dst_addr;
        logic to_file;
        logic use_bsr;
        logic [2:0] bit_num;
        logic [11:0] literal;
        logic [1:0] ptr_sel;
        logic [19:0] target;
        logic fast;
        tbl_mode_t tbl_mode;
        logic tbl_write;
    } fields_t;

    function automatic logic is_double_first(input logic [15:0] w);
        return (w[15:12] == 4'hC) || (w[15:9] == 7'h76) || (w[15:8] == 8'hEE) || (w[15:8] == 8'hEF);
    endfunction

endpackage

/* hw/core_link_if.sv */
`timescale 1ns/10ps
`include "dec_defines.svh"

interface core_link_if;
    logic [`PHASE_W-1:0] phase;
    logic cycle_end;
    logic [15:0] word1;
    logic [15:0] word2;
    dec_pkg::fields_t f;

    modport seq_mp (output phase, output cycle_end);
    modport ext_mp (input word1, input word2, output f);
    modport top_mp (input phase, input cycle_end, input f, output word1, output word2);
endinterface

/* hw/cycle_sequencer.sv */
`timescale 1ns/10ps
`include "dec_defines.svh"

module cycle_sequencer #(
    parameter int OSC_PER_ICYCLE = `OSC_PER_ICYCLE
) (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    // phase towards the decoder
    core_link_if.seq_mp lnk
);
    localparam logic [`PHASE_W-1:0] PHASE_LAST = `PHASE_W'(OSC_PER_ICYCLE - 1);

    logic [`PHASE_W-1:0] phase;
    logic [`PHASE_W-1:0] next_phase;

    always_comb begin
        next_phase = (phase == PHASE_LAST) ? '0 : phase + `PHASE_W'(1);
    end

    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            phase <= '0;
        end else begin
            phase <= next_phase;
        end
    end

    assign lnk.phase = phase;
    assign lnk.cycle_end = (phase == PHASE_LAST);

    sequence s_quarter;
        !lnk.cycle_end [*3] ##1 lnk.cycle_end;
    endsequence

    property p_phase_wrap;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        lnk.cycle_end |=> (phase == 2'h0) and s_quarter;
    endproperty
    a_phase_wrap: assert property (p_phase_wrap) else $error("instruction cycle is not four clocks");

endmodule // cycle_sequencer

/* hw/field_extractor.sv */
`timescale 1ns/10ps
`include "dec_defines.svh"

module field_extractor (
    // words in, fields out
    core_link_if.ext_mp lnk
);
    import dec_pkg::*;

    // used only by the group sort; field shaping decodes the words itself
    function automatic group_t classify(input logic [15:0] w);
        if (w[15:12] == `NIB_SECOND) return GRP_CTRL;
        if (w[15:8] == `HI_MOVLB) return GRP_LIT;
        if (w[15:8] == `HI_RETLW) return GRP_CTRL;
        if (w[15:11] == `HI_LITS) return GRP_LIT;
        if (w[15:8] == 8'h00) return GRP_CTRL;
        if (w[15:12] >= 4'h7 && w[15:12] <= 4'hB) return GRP_BIT;
        if (w[15:12] == 4'hD) return GRP_CTRL;
        if (w[15:12] == 4'hE) begin
            if (w[15:8] >= `HI_EXT_LO && w[15:8] <= `HI_EXT_HI) return GRP_LIT;
            if (w[15:8] == `HI_LFSR) return GRP_LIT;
            return GRP_CTRL;
        end
        return GRP_BYTE;
    endfunction

    logic [15:0] w1;
    logic [15:0] w2;

    always_comb begin
        w1 = lnk.word1;
        w2 = lnk.word2;
        lnk.f = '0;
        lnk.f.grp = classify(w1);
        lnk.f.dbl = is_double_first(w1);
        lnk.f.nop = (w1[15:12] == `NIB_SECOND) || (w1 == `OP_NOP);
        lnk.f.ext = (w1[15:8] >= `HI_EXT_LO && w1[15:8] <= `HI_EXT_HI) || (w1 == `OP_CALLW);
        lnk.f.file_addr = (w1[15:12] == `NIB_MOVFF) ? w1[11:0] : {4'h0, w1[7:0]};
        lnk.f.dst_addr = w2[11:0];
        lnk.f.to_file = w1[9];
        lnk.f.use_bsr = w1[8];
        lnk.f.bit_num = w1[11:9];
        lnk.f.literal = (w1[15:8] == `HI_LFSR) ? {w1[3:0], w2[7:0]} : {4'h0, w1[7:0]};
        lnk.f.ptr_sel = (w1[15:8] == `HI_LFSR) ? w1[5:4] : w1[7:6];
        if (w1[15:9] == `HI_CALL || w1[15:8] == `HI_GOTO) begin
            lnk.f.target = {w2[11:0], w1[7:0]};
        end else if (w1[15:11] == `HI_BRA || w1[15:11] == `HI_RCALL) begin
            lnk.f.target = {9'h000, w1[10:0]};
        end else begin
            lnk.f.target = {12'h000, w1[7:0]};
        end
        lnk.f.fast = (w1[15:9] == `HI_CALL) ? w1[8] : w1[0];
        lnk.f.tbl_mode = tbl_mode_t'(w1[1:0]);
        lnk.f.tbl_write = w1[2];
    end

endmodule // field_extractor

/* hw/mcu_instruction_format_decoder.sv */
`timescale 1ns/10ps
`include "dec_defines.svh"

module mcu_instruction_format_decoder #(
    parameter int OSC_PER_ICYCLE = `OSC_PER_ICYCLE
) (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    // program memory side
    input wire logic [`WORD_W-1:0] prog_word_in,
    output logic word_taken_out,
    // datapath condition, sampled on the last clock of a cycle
    input wire logic cond_true_in,
    // cycle timing
    output logic cycle_start_out,
    output logic issue_out,
    // decoded instruction
    output dec_pkg::group_t group_out,
    output logic nop_out,
    output logic double_word_out,
    output logic extended_out,
    output logic [11:0] file_addr_out,
    output logic [11:0] dst_addr_out,
    output logic dest_to_file_out,
    output logic bank_from_bsr_out,
    output logic [2:0] bit_num_out,
    output logic [11:0] literal_out,
    output logic [1:0] ptr_sel_out,
    output logic [19:0] target_out,
    output logic fast_mode_out,
    output dec_pkg::tbl_mode_t table_mode_out,
    output logic table_write_out
);
    import dec_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // sequencer and field extraction

    core_link_if lnk ();

    cycle_sequencer #(
        .OSC_PER_ICYCLE(OSC_PER_ICYCLE)
    ) u_seq (
        .clk_sys_in(clk_sys_in),
        .reset_n_in(reset_n_in),
        .lnk(lnk.seq_mp)
    );

    field_extractor u_ext (
        .lnk(lnk.ext_mp)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // cycle length of the instruction under execution

    function automatic logic needs_two(input logic [15:0] w, input logic cond);
        logic jump;
        logic skip;
        jump = (w[15:1] == `OP_RETFIE) || (w[15:1] == `OP_RETURN) || (w[15:8] == `HI_RETLW)
            || (w[15:11] == `HI_BRA) || (w[15:11] == `HI_RCALL) || (w == `OP_CALLW)
            || (w[15:4] == `TOP_MISC && w[3]);
        skip = (w[15:11] == `HI_BRANCH) || (w[15:11] == `HI_CPFS) || (w[15:10] == `HI_DECFSZ)
            || (w[15:10] == `HI_INCFSZ) || (w[15:10] == `HI_INFSNZ) || (w[15:10] == `HI_DCFSNZ)
            || (w[15:13] == `HI_BTFS);
        return jump || (skip && cond);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // instruction state

    state_t state;
    state_t next_state;
    logic [15:0] ir1;
    logic [15:0] next_ir1;
    fields_t fld;
    fields_t next_fld;
    logic issue;
    logic next_issue;
    logic taken;
    logic next_taken;
    logic cstart;
    logic flush_now;
    logic take_single;

    // the pair goes out together, so the first word is replayed from ir1
    assign lnk.word1 = (state == ST_SECOND) ? ir1 : prog_word_in;
    assign lnk.word2 = prog_word_in;
    assign flush_now = (state == ST_EXEC) && needs_two(ir1, cond_true_in);
    // fresh single word: its fields show one clock later
    assign take_single = lnk.cycle_end && state != ST_SECOND && !flush_now && !is_double_first(prog_word_in);

    always_comb begin
        next_state = state;
        next_ir1 = ir1;
        next_fld = fld;
        next_issue = 1'b0;
        next_taken = 1'b0;
        if (lnk.cycle_end) begin
            next_taken = 1'b1;
            unique case (state)
                ST_SECOND: begin
                    next_fld = lnk.f;
                    next_issue = 1'b1;
                    next_state = ST_DBL;
                end
                ST_EXEC, ST_IDLE, ST_DBL, ST_FLUSH: begin
                    if (flush_now) begin
                        // extra cycle burns as a no-op; fetch unit keeps the word
                        next_taken = 1'b0;
                        next_fld.nop = 1'b1;
                        next_issue = 1'b1;
                        next_state = ST_FLUSH;
                    end else begin
                        next_ir1 = prog_word_in;
                        if (is_double_first(prog_word_in)) begin
                            next_state = ST_SECOND;
                        end else begin
                            next_fld = lnk.f;
                            next_issue = 1'b1;
                            next_state = ST_EXEC;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state <= ST_IDLE;
            ir1 <= 16'h0000;
            fld <= '0;
            issue <= 1'b0;
            taken <= 1'b0;
            cstart <= 1'b0;
        end else begin
            state <= next_state;
            ir1 <= next_ir1;
            fld <= next_fld;
            issue <= next_issue;
            taken <= next_taken;
            cstart <= lnk.cycle_end;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs

    assign word_taken_out = taken;
    assign cycle_start_out = cstart;
    assign issue_out = issue;
    assign group_out = fld.grp;
    assign nop_out = fld.nop;
    assign double_word_out = fld.dbl;
    assign extended_out = fld.ext;
    assign file_addr_out = fld.file_addr;
    assign dst_addr_out = fld.dst_addr;
    assign dest_to_file_out = fld.to_file;
    assign bank_from_bsr_out = fld.use_bsr;
    assign bit_num_out = fld.bit_num;
    assign literal_out = fld.literal;
    assign ptr_sel_out = fld.ptr_sel;
    assign target_out = fld.target;
    assign fast_mode_out = fld.fast;
    assign table_mode_out = fld.tbl_mode;
    assign table_write_out = fld.tbl_write;

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!reset_n_in);

    sequence s_hold_pair;
        !issue_out [*4] ##1 (issue_out && double_word_out);
    endsequence

    sequence s_full_cycle;
        !cycle_start_out [*3] ##1 cycle_start_out;
    endsequence

    property p_pair_held;
        lnk.cycle_end && state != ST_SECOND && !flush_now && is_double_first(prog_word_in)
            |=> s_hold_pair;
    endproperty
    a_pair_held: assert property (p_pair_held) else $error("double word not issued one cycle later");

    property p_double_two;
        issue_out && double_word_out |=> s_full_cycle;
    endproperty
    a_double_two: assert property (p_double_two) else $error("double word exec cycle not four clocks");

    property p_flush;
        lnk.cycle_end && flush_now |=> issue_out && nop_out && !word_taken_out ##4 word_taken_out;
    endproperty
    a_flush: assert property (p_flush) else $error("taken instruction lacks its no-op cycle");

    property p_single;
        lnk.cycle_end && state == ST_EXEC && !needs_two(ir1, cond_true_in) |=> word_taken_out;
    endproperty
    a_single: assert property (p_single) else $error("single word took more than one cycle");

    property p_second_nop;
        lnk.cycle_end && state != ST_SECOND && !flush_now && prog_word_in[15:12] == `NIB_SECOND
            |=> issue_out && nop_out && group_out == GRP_CTRL;
    endproperty
    a_second_nop: assert property (p_second_nop) else $error("lone second word not a no-op");

    property p_dest;
        take_single |=> dest_to_file_out == $past(prog_word_in[9]);
    endproperty
    a_dest: assert property (p_dest) else $error("destination select wrong");

    property p_access;
        take_single |=> bank_from_bsr_out == $past(prog_word_in[8]);
    endproperty
    a_access: assert property (p_access) else $error("access select wrong");

    property p_bitnum;
        issue_out && group_out == GRP_BIT |-> bit_num_out == $past(prog_word_in[11:9]) || nop_out;
    endproperty
    a_bitnum: assert property (p_bitnum) else $error("bit number wrong");

    property p_table;
        take_single
            |=> table_mode_out == tbl_mode_t'($past(prog_word_in[1:0]));
    endproperty
    a_table: assert property (p_table) else $error("table pointer mode wrong");

    property p_goto_target;
        lnk.cycle_end && state == ST_SECOND && (ir1[15:9] == `HI_CALL || ir1[15:8] == `HI_GOTO)
            |=> target_out[19:8] == $past(prog_word_in[11:0]) && double_word_out && issue_out;
    endproperty
    a_goto_target: assert property (p_goto_target) else $error("long target not from both words");

    property p_group_byte;
        take_single && prog_word_in[15:12] >= 4'h1 && prog_word_in[15:12] <= 4'h6 |=> group_out == GRP_BYTE;
    endproperty
    a_group_byte: assert property (p_group_byte) else $error("byte operation sorted wrong");

    property p_group_bit;
        take_single && prog_word_in[15:12] >= 4'h7 && prog_word_in[15:12] <= 4'hB |=> group_out == GRP_BIT;
    endproperty
    a_group_bit: assert property (p_group_bit) else $error("bit operation sorted wrong");

    property p_ext;
        take_single && prog_word_in[15:10] == 6'h3A |=> extended_out && group_out == GRP_LIT;
    endproperty
    a_ext: assert property (p_ext) else $error("extended operation not flagged");

    property p_file;
        take_single |=> file_addr_out == {4'h0, $past(prog_word_in[7:0])};
    endproperty
    a_file: assert property (p_file) else $error("file address wrong");

    property p_literal;
        take_single |=> literal_out == {4'h0, $past(prog_word_in[7:0])};
    endproperty
    a_literal: assert property (p_literal) else $error("short literal wrong");

    property p_fast;
        take_single |=> fast_mode_out == $past(prog_word_in[0]);
    endproperty
    a_fast: assert property (p_fast) else $error("fast mode bit wrong");

    property p_issue_on_start;
        issue_out |-> cycle_start_out;
    endproperty
    a_issue_on_start: assert property (p_issue_on_start) else $error("issue off the cycle start");

    property p_taken_pulse;
        word_taken_out |-> cycle_start_out ##1 !word_taken_out;
    endproperty
    a_taken_pulse: assert property (p_taken_pulse) else $error("word taken pulse malformed");

    property p_pair_dst;
        lnk.cycle_end && state == ST_SECOND |=> dst_addr_out == $past(prog_word_in[11:0]) && word_taken_out;
    endproperty
    a_pair_dst: assert property (p_pair_dst) else $error("second word field wrong");

    property p_lfsr_pair;
        lnk.cycle_end && state == ST_SECOND && ir1[15:8] == `HI_LFSR
            |=> literal_out == {$past(ir1[3:0]), $past(prog_word_in[7:0])};
    endproperty
    a_lfsr_pair: assert property (p_lfsr_pair) else $error("long literal not from both words");

    property p_first_held;
        lnk.cycle_end && state != ST_SECOND && !flush_now && is_double_first(prog_word_in)
            |=> word_taken_out && !issue_out && $stable(group_out);
    endproperty
    a_first_held: assert property (p_first_held) else $error("first word issued alone");

endmodule // mcu_instruction_format_decoder

/* verif/prog_fetch_model.sv */
`timescale 1ns/10ps

module prog_fetch_model (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    // decoder side
    input wire logic word_taken_in,
    output logic [15:0] prog_word_out,
    output logic cond_true_out
);
    logic [15:0] mem [0:255];
    logic cnd [0:255];
    logic [7:0] ptr;

    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 16'h0000;
            cnd[i] = 1'b0;
        end
    end

    // a refused word is simply offered again
    always @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ptr <= 8'h00;
        end else if (word_taken_in) begin
            ptr <= ptr + 8'h01;
        end
    end

    assign prog_word_out = mem[ptr];
    // condition belongs to the word taken last
    assign cond_true_out = (ptr == 8'h00) ? 1'b0 : cnd[ptr - 8'h01];
endmodule // prog_fetch_model

/* verif/mcu_instruction_format_decoder_tb_top.sv */
`timescale 1ns/10ps
`define CHK_EQ(a, b) begin comparisons++; if ((a) !== (b)) begin n_errors++; \
    $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (a), (b)); end end

module mcu_instruction_format_decoder_tb_top;
    import dec_pkg::*;

    typedef struct {fields_t e; fields_t m; int gap; logic wt;} note_t;

    logic clk_sys_in;
    logic reset_n_in;
    logic [15:0] prog_word_in;
    logic cond_true_in;
    logic word_taken_out;
    logic cycle_start_out;
    logic issue_out;
    fields_t act;
    int n_errors = 0;
    int comparisons = 0;
    int pc = 0;
    int since_cs = 0;
    int since_iss = 0;
    logic seen_cs = 1'b0;
    logic [15:0] r;
    note_t notes[$];

    initial clk_sys_in = 1'b0;
    always #10 clk_sys_in = ~clk_sys_in;

    mcu_instruction_format_decoder i_mcu_instruction_format_decoder (
        .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
        .prog_word_in(prog_word_in), .word_taken_out(word_taken_out),
        .cond_true_in(cond_true_in), .cycle_start_out(cycle_start_out), .issue_out(issue_out),
        .group_out(act.grp), .nop_out(act.nop), .double_word_out(act.dbl), .extended_out(act.ext),
        .file_addr_out(act.file_addr), .dst_addr_out(act.dst_addr), .dest_to_file_out(act.to_file),
        .bank_from_bsr_out(act.use_bsr), .bit_num_out(act.bit_num), .literal_out(act.literal),
        .ptr_sel_out(act.ptr_sel), .target_out(act.target), .fast_mode_out(act.fast),
        .table_mode_out(act.tbl_mode), .table_write_out(act.tbl_write)
    );

    prog_fetch_model i_prog_fetch_model (
        .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .word_taken_in(word_taken_out),
        .prog_word_out(prog_word_in), .cond_true_out(cond_true_in)
    );

    ////////////////////////////////////////////////////////////////////////
    // kind: 0 plain, 1 always two cycles, 2 condition true, 3 condition false
    task automatic add(input logic [15:0] w1, input logic [15:0] w2, input group_t g, input int kind);
        note_t n;
        note_t f;
        logic dbl;
        logic call;
        dbl = (w1[15:12] == 4'hC) || (w1[15:9] == 7'h76) || (w1[15:8] == 8'hEE) || (w1[15:8] == 8'hEF);
        call = (w1[15:9] == 7'h76);
        n.e = '0;
        n.e.grp = g;
        n.e.nop = (w1 == 16'h0000) || (w1[15:12] == 4'hF);
        n.e.dbl = dbl;
        n.e.ext = (w1[15:10] == 6'h3A) || (w1 == 16'h0014);
        n.e.file_addr = (w1[15:12] == 4'hC) ? w1[11:0] : {4'h0, w1[7:0]};
        n.e.dst_addr = w2[11:0];
        n.e.to_file = w1[9];
        n.e.use_bsr = w1[8];
        n.e.bit_num = w1[11:9];
        n.e.literal = (w1[15:8] == 8'hEE) ? {w1[3:0], w2[7:0]} : {4'h0, w1[7:0]};
        n.e.ptr_sel = (w1[15:8] == 8'hEE) ? w1[5:4] : w1[7:6];
        if (call || w1[15:8] == 8'hEF) begin
            n.e.target = {w2[11:0], w1[7:0]};
        end else if (w1[15:12] == 4'hD) begin
            n.e.target = {9'h000, w1[10:0]};
        end else begin
            n.e.target = {12'h000, w1[7:0]};
        end
        n.e.fast = call ? w1[8] : w1[0];
        n.e.tbl_mode = tbl_mode_t'(w1[1:0]);
        n.e.tbl_write = w1[2];
        n.m = '1;
        if (!dbl) begin
            n.m.dst_addr = 12'h000;
        end
        n.gap = (notes.size() == 0 && pc == 0) ? 0 : (dbl ? 8 : 4);
        n.wt = 1'b1;
        i_prog_fetch_model.mem[pc] = w1;
        i_prog_fetch_model.cnd[pc] = (kind == 2) ? 1'b1 : ((kind == 3) ? 1'b0 : 1'($urandom));
        pc++;
        if (dbl) begin
            i_prog_fetch_model.mem[pc] = w2;
            i_prog_fetch_model.cnd[pc] = 1'($urandom);
            pc++;
        end
        notes.push_back(n);
        if (kind == 1 || kind == 2) begin
            f = n;
            f.e.nop = 1'b1;
            f.gap = 4;
            f.wt = 1'b0;
            notes.push_back(f);
        end
    endtask

    task automatic close_out();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    always @(negedge clk_sys_in) begin
        note_t n;
        if (reset_n_in) begin
            since_cs++;
            since_iss++;
            if (cycle_start_out === 1'b1) begin
                if (seen_cs) `CHK_EQ(since_cs, 4)
                seen_cs = 1'b1;
                since_cs = 0;
            end
            if (issue_out === 1'b1 && notes.size() != 0) begin
                n = notes.pop_front();
                `CHK_EQ(act & n.m, n.e & n.m)
                `CHK_EQ(word_taken_out, n.wt)
                `CHK_EQ(cycle_start_out, 1'b1)
                if (n.gap != 0) `CHK_EQ(since_iss, n.gap)
                since_iss = 0;
            end
        end
    end

    initial begin
        repeat (20000) @(posedge clk_sys_in);
        n_errors++;
        close_out();
    end

    initial begin
        reset_n_in = 1'b0;
        void'($urandom(65));
        @(posedge clk_sys_in);
        add(16'h0000, 16'h0000, GRP_CTRL, 0);
        add(16'h2A35, 16'h0000, GRP_BYTE, 0);
        add(16'h2535, 16'h0000, GRP_BYTE, 0);
        add(16'h7E81, 16'h0000, GRP_BIT, 0);
        add(16'h9345, 16'h0000, GRP_BIT, 0);
        add(16'h0E5A, 16'h0000, GRP_LIT, 0);
        add(16'h0155, 16'h0000, GRP_LIT, 0);
        add(16'hEE12, 16'hF0AB, GRP_LIT, 0);
        add(16'hC123, 16'hF456, GRP_BYTE, 0);
        add(16'hED34, 16'hF789, GRP_CTRL, 0);
        add(16'hEC12, 16'hF345, GRP_CTRL, 0);
        add(16'hEF56, 16'hF0CD, GRP_CTRL, 0);
        add(16'hF123, 16'h0000, GRP_CTRL, 0);
        add(16'hE801, 16'h0000, GRP_LIT, 0);
        add(16'h0014, 16'h0000, GRP_CTRL, 1);
        add(16'h0C55, 16'h0000, GRP_CTRL, 1);
        add(16'hD123, 16'h0000, GRP_CTRL, 1);
        add(16'hE305, 16'h0000, GRP_CTRL, 2);
        add(16'h6210, 16'h0000, GRP_BYTE, 2);
        add(16'h2C10, 16'h0000, GRP_BYTE, 3);
        add(16'hB345, 16'h0000, GRP_BIT, 2);
        add(16'h4A10, 16'h0000, GRP_BYTE, 2);
        for (int m = 0; m < 12; m++) begin
            add(16'h0008 + 16'(m), 16'h0000, GRP_CTRL, 1);
        end
        for (int k = 0; k < 6; k++) begin
            r = 16'($urandom);
            add({4'h1, r[11:0]}, 16'h0000, GRP_BYTE, 0);
            add(16'h8000 + {3'h0, r[12:0]}, 16'h0000, GRP_BIT, 0);
        end
        repeat (4) @(posedge clk_sys_in);
        reset_n_in <= 1'b1;
        for (int i = 0; i < 5000 && notes.size() != 0; i++) begin
            @(posedge clk_sys_in);
        end
        if (notes.size() != 0) begin
            n_errors++;
        end
        @(posedge clk_sys_in);
        reset_n_in <= 1'b0;
        @(negedge clk_sys_in);
        `CHK_EQ({issue_out, cycle_start_out, word_taken_out, act.nop, act.dbl}, 5'h00)
        `CHK_EQ(act.grp, GRP_BYTE)
        // cadence restarts from zero after the second release
        seen_cs = 1'b0;
        @(posedge clk_sys_in);
        reset_n_in <= 1'b1;
        repeat (3) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        `CHK_EQ({issue_out, cycle_start_out, word_taken_out}, 3'h0)
        @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        `CHK_EQ({issue_out, cycle_start_out, word_taken_out, act.nop}, 4'hF)
        close_out();
    end
endmodule // mcu_instruction_format_decoder_tb_top
